/* dv/qctu_enc_model.sv */
// Incremental encoder model producing Gray-coded A and B levels.
// Assumes steps are requested one cycle at a time by the bench.
`timescale 1ns/1ps
module qctu_enc_model (
    input wire logic i_clk,
    input wire logic i_step,
    input wire logic i_up,
    input wire logic i_jump,
    output logic o_a,
    output logic o_b
);
    logic [1:0] ph_r = 2'h0;
    always @(posedge i_clk) begin
        if (i_jump) ph_r <= ph_r + 2'h2;
        else if (i_step) ph_r <= i_up ? ph_r + 2'h1 : ph_r - 2'h1;
    end
    assign o_a = ph_r[1];
    assign o_b = ph_r[0] ^ ph_r[1];
endmodule : qctu_enc_model

/* dv/qctu_monitor.sv */
// Assertions on the ports of the quadrature counter core.
// Assumes it is bound to qctu_core and sees its display, relay, menu request and show-identity outputs plus clock, reset and escape key.
`timescale 1ns/1ps
module qctu_monitor (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic I_KEY_ESC,
    input wire qctu_pkg::qctu_disp_t O_DISP,
    input wire logic [qctu_pkg::RELAYS-1:0] O_RELAY,
    input wire logic O_MENU_REQ,
    input wire logic O_SHOW_ID
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);
    sequence s_warn;
        O_DISP.overflow_warning || O_DISP.underflow_warning;
    endsequence
    a_warn_opens_relays: assert property (s_warn ##1 s_warn |-> !O_RELAY)
        else $error("relay closed during warning");
    a_id_relays_off: assert property (O_SHOW_ID |-> !O_RELAY)
        else $error("relay closed during identity phase");
    a_menu_one_pulse: assert property (O_MENU_REQ |=> !O_MENU_REQ)
        else $error("menu request longer than one cycle");
    a_menu_needs_hold: assert property (O_MENU_REQ |->
        $past(I_KEY_ESC, 8) && $past(I_KEY_ESC, 20))
        else $error("menu request without long escape hold");
    a_led_off_main: assert property
        (O_DISP.sel == qctu_pkg::SEL_MAIN |-> !O_DISP.led_f)
        else $error("indicator lit for main counter");
    a_led_lit_total: assert property
        (O_DISP.sel == qctu_pkg::SEL_TOT |-> O_DISP.led_f)
        else $error("indicator dark for totalizer");
    a_point_limit: assert property (O_DISP.dp_pos <= qctu_pkg::DP_MAX)
        else $error("decimal point beyond four digits");
    a_warn_exclusive: assert property
        (!(O_DISP.overflow_warning && O_DISP.underflow_warning))
        else $error("both warnings at once");
    a_view_range: assert property (O_DISP.view_idx <= qctu_pkg::VIEW_LAST)
        else $error("view index out of range");
endmodule : qctu_monitor

/* dv/quadrature_counter_threshold_unit_tb.sv */
// Self-checking bench of the quadrature counter core.
// Assumes the encoder model and the bound checker beside the core.
`timescale 1ns/1ps
module quadrature_counter_threshold_unit_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [4:0] key = 5'h00;
    logic step = 1'b0, up = 1'b1, jump = 1'b0, rclr = 1'b0, p1 = 1'b0;
    logic mact = 1'b0, save = 1'b0;
    logic [15:0] id_word;
    logic enc_a, enc_b, menu_req, show_id;
    logic [3:0] relay;
    qctu_pkg::qctu_cfg_t cfg = '0;
    qctu_pkg::qctu_image_t img = '0, bk;
    qctu_pkg::qctu_disp_t disp;
    int fail_count = 0, n_tests = 0, pulses;
    always #4 clk = ~clk;
    qctu_enc_model enc (.i_clk(clk), .i_step(step), .i_up(up),
        .i_jump(jump), .o_a(enc_a), .o_b(enc_b));
    qctu_core #(.ID_CYC(20), .VIEW_CYC(50), .ESC_CYC(30), .FRZ_CYC(10),
        .BLINK_CYC(4)) DUT (.I_CLK(clk), .I_RST_B(rst_b), .I_ENC_A(enc_a),
        .I_ENC_B(enc_b), .I_KEY_ESC(key[0]), .I_KEY_ENTER(key[1]),
        .I_KEY_UP(key[2]), .I_KEY_DOWN(key[3]), .I_KEY_RESET(key[4]),
        .I_PROGRAMMABLE_INPUT_ONE(p1), .I_PROGRAMMABLE_INPUT_TWO(p1),
        .I_CFG(cfg), .I_MENU_ACTIVE(mact), .I_SAVE_START(save),
        .I_REMOTE_CLEAR(rclr), .I_RESTORE(img), .O_DISP(disp),
        .O_RELAY(relay), .O_MENU_REQ(menu_req), .O_SHOW_ID(show_id),
        .O_ID_WORD(id_word), .O_BACKUP(bk));
    task automatic check(string what, logic [47:0] seen, logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic press(int k);
        key[k] = 1'b1;
        cyc(6);
        key[k] = 1'b0;
        cyc(6);
    endtask : press
    task automatic steps(int n, logic dir);
        up = dir;
        repeat (n) begin
            step = 1'b1;
            cyc(1);
            step = 1'b0;
            cyc(7);
        end
        cyc(8);
    endtask : steps
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    initial begin
        cfg.scale_multiplier = 16'h0001;
        cfg.divider = 16'h0001;
        cfg.relay_threshold[0] = 32'h00000005;
        cfg.relay_threshold[1] = 32'h00000064;
        cfg.active_closed = 4'h3;
        img.sel = qctu_pkg::SEL_CYC;
        img.cyc_cnt = 32'h00000007;
        cyc(12);
        rst_b = 1'b1;
        cyc(24);
        check("show_id", show_id, 48'h0);
        check("sel", disp.sel, qctu_pkg::SEL_CYC);
        check("cycles", bk.cyc_cnt, 48'h7);
        check("id", id_word, qctu_pkg::ID_WORD_DEFAULT);
        press(2);
        check("sel", disp.sel, qctu_pkg::SEL_TOT);
        press(2);
        check("sel", disp.sel, qctu_pkg::SEL_MAIN);
        steps(8, 1'b1);
        check("value", disp.value, 48'h2);
        jump = 1'b1;
        cyc(1);
        jump = 1'b0;
        cyc(8);
        check("main", bk.main_cnt, 48'h8);
        cfg.scale_multiplier = 16'h0004;
        cyc(4);
        check("value", disp.value, 48'h8);
        check("total", bk.tot_cnt, 48'h8);
        check("relay", relay, 48'h1);
        press(4);
        check("main", bk.main_cnt, 48'h8);
        press(1);
        check("main", bk.main_cnt, 48'h0);
        repeat (5) press(3);
        check("view", disp.view_idx, 48'h5);
        cfg.scale_multiplier = 16'h0001;
        cyc(2);
        check("slot", disp.value, 48'h8);
        cyc(60);
        check("view", disp.view_idx, 48'h0);
        cfg.input_one_target = qctu_pkg::TGT_MAIN;
        steps(4, 1'b1);
        p1 = 1'b1;
        cyc(6);
        p1 = 1'b0;
        cyc(4);
        check("main", bk.main_cnt, 48'h0);
        repeat (5) press(3);
        check("slot", disp.value, 48'h8);
        steps(4, 1'b1);
        rclr = 1'b1;
        cyc(1);
        rclr = 1'b0;
        cyc(4);
        check("main", bk.main_cnt, 48'h0);
        save = 1'b1;
        cyc(1);
        save = 1'b0;
        cfg.active_closed = 4'h2;
        cyc(4);
        check("relay", relay, 48'h0);
        cyc(10);
        check("relay", relay, 48'h1);
        mact = 1'b1;
        press(2);
        steps(4, 1'b1);
        mact = 1'b0;
        check("sel", disp.sel, qctu_pkg::SEL_MAIN);
        check("main", bk.main_cnt, 48'h4);
        cfg.scale_multiplier = 16'hFFFF;
        steps(70, 1'b1);
        check("over", disp.overflow_warning, 48'h1);
        check("main", bk.main_cnt, 48'h3E);
        check("relay", relay, 48'h0);
        steps(1, 1'b0);
        check("over", disp.overflow_warning, 48'h0);
        key[0] = 1'b1;
        pulses = 0;
        repeat (40) begin
            cyc(1);
            pulses += menu_req;
        end
        key[0] = 1'b0;
        cyc(4);
        check("menu", pulses, 48'h1);
        close_out();
    end
    initial begin
        #100000;
        fail_count++;
        close_out();
    end
endmodule : quadrature_counter_threshold_unit_tb
bind qctu_core qctu_monitor mon (.I_CLK(I_CLK), .I_RST_B(I_RST_B),
    .I_KEY_ESC(I_KEY_ESC), .O_DISP(O_DISP), .O_RELAY(O_RELAY),
    .O_MENU_REQ(O_MENU_REQ), .O_SHOW_ID(O_SHOW_ID));

/* hdl/qctu_core.sv */
// Quadrature counter core: decoding, three counters, scaling, zeroing
// store, display selection and relay threshold comparison.
// Assumes pins and keys are asynchronous, configuration is quasi-static.
//
// Behaviour
// - Decode single A/B edges, four counts per cycle, show whole cycles; a step changing both pins is ignored.
// - Scale internal count by multiplier over divider before display.
// - Every main counter step also steps the totalizer equally.
// - Flag overflow above 999999 and underflow below -99999, show warning.
// - During a warning block that count direction and open all relays.
// - Clear displayed counter by keypad or remote write, configured counter by programmable input.
// - Keypad clear acts only when enter follows the reset key.
// - Keypad main clears push the old value into a five-entry store.
// - Newest value in slot one, oldest in five; values never rescaled.
// - Autoreset and programmable input clears leave the store untouched.
// - Down key steps thresholds then store; 5 s idle returns.
// - Counting continues; relays and autoreset freeze 0.1 s on save.
// - Show identity at power-up, then restore counters and selection.
// - Up key cycles main, cycles, totalizer in fixed order.
// - Indicator off for main, blinking for cycles, lit for totalizer.
// - Twelve-digit totalizer; above six digits blink left point.
// - Down key toggles totalizer half; upper half blinks right point.
// - Decimal point position limited to four fractional digits.
// - Half selection kept across switching; totalizer clear selects lower.
// - Escape held at least 2 s requests the main menu.
// - Relay active once value reaches threshold; active closed or open.
// - Relays three and four compare main or cycles counter.
`timescale 1ns/1ps
module qctu_core #(
    parameter int unsigned ID_CYC = qctu_pkg::ID_SHOW_MS * qctu_pkg::CLK_KHZ,
    parameter int unsigned VIEW_CYC = qctu_pkg::VIEW_TMO_MS * qctu_pkg::CLK_KHZ,
    parameter int unsigned ESC_CYC = qctu_pkg::ESC_HOLD_MS * qctu_pkg::CLK_KHZ,
    parameter int unsigned FRZ_CYC = qctu_pkg::SAVE_FRZ_MS * qctu_pkg::CLK_KHZ,
    parameter int unsigned BLINK_CYC =
        qctu_pkg::BLINK_HALF_MS * qctu_pkg::CLK_KHZ,
    // Arbitrary identification value.
    parameter logic [15:0] ID_WORD = qctu_pkg::ID_WORD_DEFAULT
) (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic I_ENC_A,
    input wire logic I_ENC_B,
    input wire logic I_KEY_ESC,
    input wire logic I_KEY_ENTER,
    input wire logic I_KEY_UP,
    input wire logic I_KEY_DOWN,
    input wire logic I_KEY_RESET,
    input wire logic I_PROGRAMMABLE_INPUT_ONE,
    input wire logic I_PROGRAMMABLE_INPUT_TWO,
    input wire qctu_pkg::qctu_cfg_t I_CFG,
    input wire logic I_MENU_ACTIVE,
    input wire logic I_SAVE_START,
    input wire logic I_REMOTE_CLEAR,
    input wire qctu_pkg::qctu_image_t I_RESTORE,
    output qctu_pkg::qctu_disp_t O_DISP,
    output logic [qctu_pkg::RELAYS-1:0] O_RELAY,
    output logic O_MENU_REQ,
    output logic O_SHOW_ID,
    output logic [15:0] O_ID_WORD,
    output qctu_pkg::qctu_image_t O_BACKUP
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [qctu_pkg::PIN_W-1:0] sync1;
        logic [qctu_pkg::PIN_W-1:0] sync2;
        logic [qctu_pkg::PIN_W-1:0] last;
        qctu_pkg::qctu_phase_t phase;
        logic [31:0] id_cnt;
        qctu_pkg::qctu_image_t img;
        logic signed [qctu_pkg::VAL_W-1:0] main_scl;
        logic signed [qctu_pkg::VAL_W-1:0] tot_scl;
        logic ovf;
        logic unf;
        logic [qctu_pkg::ZSLOTS-1:0][qctu_pkg::VAL_W-1:0] slot;
        logic rst_armed;
        logic [3:0] view_idx;
        logic [31:0] view_cnt;
        logic [31:0] esc_cnt;
        logic menu_req;
        logic [31:0] frz_cnt;
        logic [31:0] blink_cnt;
        logic blink;
        logic [qctu_pkg::RELAYS-1:0] relay;
        qctu_pkg::qctu_disp_t disp;
    } qctu_state_t;

    qctu_state_t state_r;
    qctu_state_t state_nxt;

    // ------------------------------------------------------------------
    // Scaling
    // ------------------------------------------------------------------
    function automatic logic signed [qctu_pkg::VAL_W-1:0] qctu_scale(
        input logic signed [qctu_pkg::VAL_W-1:0] cnt,
        input logic [qctu_pkg::FAC_W-1:0] mul,
        input logic [qctu_pkg::FAC_W-1:0] div
    );
        logic signed [63:0] num;
        logic signed [63:0] den;
        num = 64'(cnt) * $signed({48'h000000000000, mul});
        den = $signed({46'h000000000000, (div == '0) ? 16'h0001 : div,
            2'h0});
        qctu_scale = qctu_pkg::VAL_W'(num / den);
    endfunction : qctu_scale

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [qctu_pkg::PIN_W-1:0] rise;
        logic [1:0] bin_cur;
        logic [1:0] bin_prev;
        logic [1:0] diff;
        logic step_up;
        logic step_dn;
        logic frozen;
        logic tot_big;
        logic upper_shown;
        logic clr_main;
        logic clr_cyc;
        logic clr_tot;
        logic push;
        logic reach;
        logic signed [qctu_pkg::VAL_W-1:0] src;
        logic signed [qctu_pkg::VAL_W-1:0] thr;
        qctu_pkg::qctu_tgt_t sel_tgt;
        rise = '0;
        bin_cur = '0;
        bin_prev = '0;
        diff = '0;
        step_up = 1'b0;
        step_dn = 1'b0;
        frozen = 1'b0;
        tot_big = 1'b0;
        upper_shown = 1'b0;
        clr_main = 1'b0;
        clr_cyc = 1'b0;
        clr_tot = 1'b0;
        push = 1'b0;
        reach = 1'b0;
        src = '0;
        thr = '0;
        sel_tgt = qctu_pkg::TGT_NONE;
        state_nxt = state_r;

        // Two-stage synchronisers and edge history.
        state_nxt.sync1 = {I_PROGRAMMABLE_INPUT_TWO, I_PROGRAMMABLE_INPUT_ONE,
            I_KEY_RESET, I_KEY_DOWN, I_KEY_UP, I_KEY_ENTER, I_KEY_ESC,
            I_ENC_B, I_ENC_A};
        state_nxt.sync2 = state_r.sync1;
        state_nxt.last = state_r.sync2;
        rise = state_r.sync2 & ~state_r.last;

        // Gray state to binary position, then signed step.
        bin_cur = {state_r.sync2[qctu_pkg::PIN_A],
            state_r.sync2[qctu_pkg::PIN_A] ^ state_r.sync2[qctu_pkg::PIN_B]};
        bin_prev = {state_r.last[qctu_pkg::PIN_A],
            state_r.last[qctu_pkg::PIN_A] ^ state_r.last[qctu_pkg::PIN_B]};
        diff = bin_cur - bin_prev;
        step_up = (diff == 2'h1);
        step_dn = (diff == 2'h3);

        frozen = (state_r.frz_cnt != '0);
        tot_big = (state_r.tot_scl >= qctu_pkg::HALF_SPLIT) ||
            (state_r.tot_scl <= -qctu_pkg::HALF_SPLIT);
        upper_shown = state_r.img.tot_upper && tot_big;

        // Blink timebase.
        if (state_r.blink_cnt >= 32'(BLINK_CYC - 1)) begin
            state_nxt.blink_cnt = '0;
            state_nxt.blink = ~state_r.blink;
        end else begin
            state_nxt.blink_cnt = state_r.blink_cnt + 32'h00000001;
        end

        // Save freeze window.
        if (I_SAVE_START) begin
            state_nxt.frz_cnt = 32'(FRZ_CYC);
        end else if (frozen) begin
            state_nxt.frz_cnt = state_r.frz_cnt - 32'h00000001;
        end

        // Escape hold detection.
        state_nxt.menu_req = 1'b0;
        if (state_r.sync2[qctu_pkg::PIN_ESC]) begin
            if (state_r.esc_cnt < 32'(ESC_CYC)) begin
                state_nxt.esc_cnt = state_r.esc_cnt + 32'h00000001;
            end
            state_nxt.menu_req = (state_r.esc_cnt == 32'(ESC_CYC - 1));
        end else begin
            state_nxt.esc_cnt = '0;
        end

        case (state_r.phase)
            qctu_pkg::PH_ID: begin
                state_nxt.id_cnt = state_r.id_cnt + 32'h00000001;
                if (state_r.id_cnt >= 32'(ID_CYC - 1)) begin
                    state_nxt.img = I_RESTORE;
                    state_nxt.phase = qctu_pkg::PH_RUN;
                end
            end
            qctu_pkg::PH_RUN: begin
                // Counting runs regardless of menu activity.
                if (step_up && !state_r.ovf) begin
                    state_nxt.img.main_cnt = state_r.img.main_cnt + 32'sh1;
                    state_nxt.img.tot_cnt = state_r.img.tot_cnt + 48'sh1;
                end else if (step_dn && !state_r.unf) begin
                    state_nxt.img.main_cnt = state_r.img.main_cnt - 32'sh1;
                    state_nxt.img.tot_cnt = state_r.img.tot_cnt - 48'sh1;
                end

                // Keypad: reset arms, enter confirms, escape cancels.
                case (state_r.img.sel)
                    qctu_pkg::SEL_MAIN: sel_tgt = qctu_pkg::TGT_MAIN;
                    qctu_pkg::SEL_CYC: sel_tgt = qctu_pkg::TGT_CYC;
                    default: sel_tgt = qctu_pkg::TGT_TOT;
                endcase
                if (!I_MENU_ACTIVE) begin
                    if (state_r.rst_armed && rise[qctu_pkg::PIN_ENT]) begin
                        state_nxt.rst_armed = 1'b0;
                        clr_main = (sel_tgt == qctu_pkg::TGT_MAIN);
                        clr_cyc = (sel_tgt == qctu_pkg::TGT_CYC);
                        clr_tot = (sel_tgt == qctu_pkg::TGT_TOT);
                        push = clr_main;
                    end else if (rise[qctu_pkg::PIN_RST]) begin
                        state_nxt.rst_armed = 1'b1;
                    end else if (rise[qctu_pkg::PIN_ESC]) begin
                        state_nxt.rst_armed = 1'b0;
                    end
                end

                // Programmable inputs and remote write clear without a push.
                if (rise[qctu_pkg::PIN_P1]) begin
                    clr_main |= (I_CFG.input_one_target == qctu_pkg::TGT_MAIN);
                    clr_cyc |= (I_CFG.input_one_target == qctu_pkg::TGT_CYC);
                    clr_tot |= (I_CFG.input_one_target == qctu_pkg::TGT_TOT);
                end
                if (rise[qctu_pkg::PIN_P2]) begin
                    clr_main |= (I_CFG.input_two_target == qctu_pkg::TGT_MAIN);
                    clr_cyc |= (I_CFG.input_two_target == qctu_pkg::TGT_CYC);
                    clr_tot |= (I_CFG.input_two_target == qctu_pkg::TGT_TOT);
                end
                if (I_REMOTE_CLEAR) begin
                    clr_main |= (sel_tgt == qctu_pkg::TGT_MAIN);
                    clr_cyc |= (sel_tgt == qctu_pkg::TGT_CYC);
                    clr_tot |= (sel_tgt == qctu_pkg::TGT_TOT);
                end

                // Autoreset on the first threshold, counts zeroings.
                thr = qctu_pkg::VAL_W'($signed(I_CFG.relay_threshold[0]));
                if (I_CFG.autoreset_en && !frozen && !clr_main &&
                    state_r.main_scl >= thr) begin
                    clr_main = 1'b1;
                    state_nxt.img.cyc_cnt = state_r.img.cyc_cnt + 32'h00000001;
                end

                if (push) begin
                    for (int k = qctu_pkg::ZSLOTS - 1; k > 0; k--) begin
                        state_nxt.slot[k] = state_r.slot[k-1];
                    end
                    state_nxt.slot[0] = state_r.main_scl;
                end
                if (clr_main) begin
                    state_nxt.img.main_cnt = '0;
                end
                if (clr_cyc) begin
                    state_nxt.img.cyc_cnt = '0;
                end
                if (clr_tot) begin
                    state_nxt.img.tot_cnt = '0;
                    state_nxt.img.tot_upper = 1'b0;
                end

                // Up key selects the next counter and leaves quick view.
                if (!I_MENU_ACTIVE && rise[qctu_pkg::PIN_UP]) begin
                    state_nxt.view_idx = qctu_pkg::VIEW_NONE;
                    case (state_r.img.sel)
                        qctu_pkg::SEL_MAIN: state_nxt.img.sel = qctu_pkg::SEL_CYC;
                        qctu_pkg::SEL_CYC: state_nxt.img.sel = qctu_pkg::SEL_TOT;
                        default: state_nxt.img.sel = qctu_pkg::SEL_MAIN;
                    endcase
                end

                // Down key: half toggle on a long totalizer, else quick view.
                if (!I_MENU_ACTIVE && rise[qctu_pkg::PIN_DN]) begin
                    state_nxt.view_cnt = '0;
                    if (state_r.img.sel == qctu_pkg::SEL_TOT && tot_big &&
                        state_r.view_idx == qctu_pkg::VIEW_NONE) begin
                        state_nxt.img.tot_upper = ~upper_shown;
                    end else if (state_r.view_idx == qctu_pkg::VIEW_LAST) begin
                        state_nxt.view_idx = qctu_pkg::VIEW_NONE;
                    end else begin
                        state_nxt.view_idx = state_r.view_idx + 4'h1;
                    end
                end else if (state_r.view_idx != qctu_pkg::VIEW_NONE) begin
                    if (state_r.view_cnt >= 32'(VIEW_CYC - 1)) begin
                        state_nxt.view_idx = qctu_pkg::VIEW_NONE;
                        state_nxt.view_cnt = '0;
                    end else begin
                        state_nxt.view_cnt = state_r.view_cnt + 32'h00000001;
                    end
                end
            end
            default: begin
                state_nxt.phase = qctu_pkg::PH_ID;
            end
        endcase

        // Scaled results and range warnings.
        state_nxt.main_scl = qctu_scale(
            qctu_pkg::VAL_W'(state_r.img.main_cnt),
            I_CFG.scale_multiplier, I_CFG.divider);
        state_nxt.tot_scl = qctu_scale(state_r.img.tot_cnt,
            I_CFG.scale_multiplier, I_CFG.divider);
        state_nxt.ovf = (state_nxt.main_scl > qctu_pkg::OVF_LIMIT);
        state_nxt.unf = (state_nxt.main_scl < qctu_pkg::UNF_LIMIT);

        // Relay comparison, frozen while parameters are saved.
        if (state_r.phase != qctu_pkg::PH_RUN) begin
            state_nxt.relay = '0;
        end else if (!frozen) begin
            for (int i = 0; i < qctu_pkg::RELAYS; i++) begin
                src = state_r.main_scl;
                if (i >= 2 && I_CFG.src_cycles[i-2]) begin
                    src = $signed({16'h0000, state_r.img.cyc_cnt});
                end
                thr = qctu_pkg::VAL_W'($signed(I_CFG.relay_threshold[i]));
                reach = (src >= thr);
                state_nxt.relay[i] = ~(reach ^ I_CFG.active_closed[i]);
            end
        end
        if (state_r.ovf || state_r.unf) begin
            state_nxt.relay = '0;
        end

        // Display image.
        state_nxt.disp.sel = state_r.img.sel;
        state_nxt.disp.view_idx = state_r.view_idx;
        state_nxt.disp.dp_pos = (I_CFG.point > qctu_pkg::DP_MAX) ?
            qctu_pkg::DP_MAX : I_CFG.point;
        state_nxt.disp.overflow_warning = state_r.ovf;
        state_nxt.disp.underflow_warning = state_r.unf;
        state_nxt.disp.dp_left_blink = 1'b0;
        state_nxt.disp.dp_right_blink = 1'b0;
        case (state_r.img.sel)
            qctu_pkg::SEL_MAIN: state_nxt.disp.led_f = 1'b0;
            qctu_pkg::SEL_CYC: state_nxt.disp.led_f = state_r.blink;
            default: state_nxt.disp.led_f = 1'b1;
        endcase
        if (state_r.view_idx >= qctu_pkg::VIEW_SLOT_FIRST) begin
            state_nxt.disp.value = state_r.slot[
                3'(state_r.view_idx - qctu_pkg::VIEW_SLOT_FIRST)];
        end else if (state_r.view_idx != qctu_pkg::VIEW_NONE) begin
            state_nxt.disp.value = qctu_pkg::VAL_W'($signed(
                I_CFG.relay_threshold[2'(state_r.view_idx - 4'h1)]));
        end else begin
            case (state_r.img.sel)
                qctu_pkg::SEL_MAIN: begin
                    state_nxt.disp.value = state_r.main_scl;
                end
                qctu_pkg::SEL_CYC: begin
                    state_nxt.disp.value =
                        $signed({16'h0000, state_r.img.cyc_cnt});
                end
                default: begin
                    if (upper_shown) begin
                        state_nxt.disp.value =
                            state_r.tot_scl / qctu_pkg::HALF_SPLIT;
                        state_nxt.disp.dp_right_blink = state_r.blink;
                    end else begin
                        state_nxt.disp.value =
                            state_r.tot_scl % qctu_pkg::HALF_SPLIT;
                        state_nxt.disp.dp_left_blink =
                            tot_big && state_r.blink;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign O_DISP = state_r.disp;
    assign O_RELAY = state_r.relay;
    assign O_MENU_REQ = state_r.menu_req;
    assign O_SHOW_ID = (state_r.phase == qctu_pkg::PH_ID);
    assign O_ID_WORD = ID_WORD;
    assign O_BACKUP = state_r.img;
endmodule : qctu_core

/* hdl/qctu_pkg.sv */
// Shared constants, field layouts and types of the quadrature counter core.
// Assumes a single 125 MHz system clock and active-high key and pin levels.
package qctu_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_KHZ = 125000;
    localparam int ID_SHOW_MS = 1000;
    localparam int VIEW_TMO_MS = 5000;
    localparam int ESC_HOLD_MS = 2000;
    localparam int SAVE_FRZ_MS = 100;
    localparam int BLINK_HALF_MS = 250;

    // ------------------------------------------------------------------
    // Sizes and limits
    // ------------------------------------------------------------------
    localparam int RELAYS = 4;
    localparam int ZSLOTS = 5;
    localparam int THR_W = 32;
    localparam int CNT_W = 32;
    localparam int VAL_W = 48;
    localparam int FAC_W = 16;
    localparam int QUAD_SHIFT = 2;
    localparam logic signed [47:0] OVF_LIMIT = 48'sh0000000F423F;
    localparam logic signed [47:0] UNF_LIMIT = -48'sh00000001869F;
    localparam logic signed [47:0] HALF_SPLIT = 48'sh0000000F4240;
    localparam logic [2:0] DP_MAX = 3'h4;
    localparam logic [3:0] VIEW_NONE = 4'h0;
    localparam logic [3:0] VIEW_SLOT_FIRST = 4'h5;
    localparam logic [3:0] VIEW_LAST = 4'h9;
    localparam logic [15:0] ID_WORD_DEFAULT = 16'h5A3C;

    // ------------------------------------------------------------------
    // Synchroniser bit positions
    // ------------------------------------------------------------------
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_ESC = 2;
    localparam int PIN_ENT = 3;
    localparam int PIN_UP = 4;
    localparam int PIN_DN = 5;
    localparam int PIN_RST = 6;
    localparam int PIN_P1 = 7;
    localparam int PIN_P2 = 8;
    localparam int PIN_W = 9;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {SEL_MAIN, SEL_CYC, SEL_TOT} qctu_sel_t;
    typedef enum logic [1:0] {TGT_NONE, TGT_MAIN, TGT_CYC, TGT_TOT} qctu_tgt_t;
    typedef enum logic {PH_ID, PH_RUN} qctu_phase_t;

    typedef struct packed {
        logic [FAC_W-1:0] scale_multiplier;
        logic [FAC_W-1:0] divider;
        logic [2:0] point;
        logic [RELAYS-1:0][THR_W-1:0] relay_threshold;
        logic [RELAYS-1:0] active_closed;
        logic [1:0] src_cycles;
        logic autoreset_en;
        qctu_tgt_t input_one_target;
        qctu_tgt_t input_two_target;
    } qctu_cfg_t;

    typedef struct packed {
        logic signed [CNT_W-1:0] main_cnt;
        logic [CNT_W-1:0] cyc_cnt;
        logic signed [VAL_W-1:0] tot_cnt;
        qctu_sel_t sel;
        logic tot_upper;
    } qctu_image_t;

    typedef struct packed {
        logic signed [VAL_W-1:0] value;
        qctu_sel_t sel;
        logic [3:0] view_idx;
        logic [2:0] dp_pos;
        logic dp_left_blink;
        logic dp_right_blink;
        logic led_f;
        logic overflow_warning;
        logic underflow_warning;
    } qctu_disp_t;
endpackage : qctu_pkg
